// ===== include/hdtg_defines.svh
`ifndef HDTG_DEFINES_SVH
`define HDTG_DEFINES_SVH
// ==========================================
// register map
`define HDTG_ADDR_CTRL      8'h00
`define HDTG_ADDR_AMP       8'h04
`define HDTG_ADDR_SQUELCH   8'h08
`define HDTG_ADDR_GAIN      8'h0C
`define HDTG_ADDR_STATUS    8'h10
`define HDTG_ADDR_TEMP      8'h14
// ==========================================
// field positions and reset values
`define HDTG_CTRL_W         5
`define HDTG_CTRL_RST       5'h00
`define HDTG_AMP_RST        8'h00
`define HDTG_SQUELCH_RST    7'h00
`define HDTG_GAIN_W         4
`define HDTG_GAIN_RST       4'h0
`define HDTG_BW_LSB         4
`define HDTG_BW_RST         3'h0
// ==========================================
// load and level encodings
`define HDTG_LOAD_OFF       2'b00
`define HDTG_LOAD_LRA       2'b01
`define HDTG_LOAD_ERM       2'b10
`define HDTG_CODE_MAX       8'sh7F
// ==========================================
// timing
`define HDTG_MCLK_HZ        100000000
`define HDTG_SLOW_OSC_HZ    32000
`define HDTG_SLOW_DIV       (`HDTG_MCLK_HZ / `HDTG_SLOW_OSC_HZ)
`define HDTG_SQUELCH_PERIODS 10'h200
`define HDTG_TEMP_PERIOD    11'h400
`define HDTG_TEMP_PERIOD_MS 32
// ==========================================
// thermal thresholds as sensor codes
`define HDTG_WARN_CODE      10'h1E0
`define HDTG_ALARM_CODE     10'h26C
`endif

// ===== include/hdtg_pkg.sv
`default_nettype none
package hdtg_pkg;
   // software control word
   typedef struct packed {
      logic       always_measure;
      logic       range_setting;
      logic       source_select;
      logic [1:0] load_select;
   } hdtg_ctrl_t;

   // register bus request
   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } hdtg_bus_t;

   typedef enum logic [1:0] {TS_IDLE, TS_WAIT, TS_MEAS} hdtg_tstate_t;
endpackage : hdtg_pkg
`default_nettype wire

// ===== src/hdtg_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "hdtg_defines.svh"

module hdtg_top #(
   parameter int          CNT_W      = 20,
   parameter int          SLOW_DIV   = `HDTG_SLOW_DIV,
   parameter logic [9:0]  WARN_CODE  = `HDTG_WARN_CODE,
   parameter logic [9:0]  ALARM_CODE = `HDTG_ALARM_CODE
) (
   input  wire logic         mclk,
   input  wire logic         rstn,
   input  wire logic [7:0]   bus_addr,
   input  wire logic [31:0]  bus_wdata,
   input  wire logic         bus_wr,
   input  wire logic         bus_rd,
   output logic      [31:0]  bus_rdata,
   input  wire logic         pwm_in,
   input  wire logic         short_detect,
   input  wire logic         host_driven_mode,
   input  wire logic [2:0]   proximity_scan_interval,
   input  wire logic         adc_busy,
   input  wire logic         temp_valid,
   input  wire logic [9:0]   temp_code,
   output logic      [7:0]   dac_code,
   output logic              motor_ground,
   output logic      [3:0]   haptic_output_gain,
   output logic              motor_short_flag,
   output logic              thermal_warn_flag,
   output logic              thermal_alarm_flag,
   output logic              warn_edge,
   output logic              alarm_edge,
   output logic              temp_start,
   output logic              ops_halt,
   output logic              results_discard,
   output logic              cycle_restart
);
   // ==========================================
   // registers
   hdtg_pkg::hdtg_bus_t     bus;
   hdtg_pkg::hdtg_ctrl_t    ctrl_reg;
   hdtg_pkg::hdtg_tstate_t  ts_reg;
   logic [7:0]        amp_reg;
   logic [6:0]        squelch_reg;
   logic [3:0]        gain_reg;
   logic [2:0]        bw_reg;
   logic [31:0]       rdata_reg;
   logic [1:0]        pwm_sync_reg;
   logic [1:0]        short_sync_reg;
   logic              pwm_last_reg;
   logic              pwm_seen_reg;
   logic              pwm_tick_reg;
   logic [CNT_W-1:0]  per_cnt_reg;
   logic [CNT_W-1:0]  high_cnt_reg;
   logic [CNT_W-1:0]  meas_per_reg;
   logic [CNT_W-1:0]  meas_high_reg;
   logic [15:0]       slow_div_reg;
   logic              slow_tick_reg;
   logic [7:0]        level_reg;
   logic [7:0]        filt_reg;
   logic [9:0]        sq_cnt_reg;
   logic [10:0]       tdiv_reg;
   logic [9:0]        temp_last_reg;
   logic [7:0]        dac_reg;
   logic              ground_reg;
   logic              short_reg;
   logic              warn_reg;
   logic              alarm_reg;
   logic              warn_edge_reg;
   logic              alarm_edge_reg;
   logic              start_reg;
   logic              halt_reg;
   logic              discard_reg;
   logic              restart_reg;

   assign bus = '{addr: bus_addr, wdata: bus_wdata, wr: bus_wr, rd: bus_rd};

   // ==========================================
   // pin synchronisers
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         pwm_sync_reg   <= 2'h0;
         short_sync_reg <= 2'h0;
      end else begin
         pwm_sync_reg   <= {pwm_sync_reg[0], pwm_in};
         short_sync_reg <= {short_sync_reg[0], short_detect};
      end
   end

   wire pwm_s   = pwm_sync_reg[1];
   wire short_s = short_sync_reg[1];

   // ==========================================
   // register bus
   wire wr_ctrl = bus.wr && bus.addr == `HDTG_ADDR_CTRL;
   wire wr_amp  = bus.wr && bus.addr == `HDTG_ADDR_AMP;
   wire wr_sq   = bus.wr && bus.addr == `HDTG_ADDR_SQUELCH;
   wire wr_gain = bus.wr && bus.addr == `HDTG_ADDR_GAIN;

   wire load_erm   = ctrl_reg.load_select == `HDTG_LOAD_ERM;
   wire load_lra   = ctrl_reg.load_select == `HDTG_LOAD_LRA;
   // code 11 is left idle: no load is defined for it
   wire hap_active = load_erm || load_lra;

   logic [31:0] rd_mux;
   wire  squelched;
   assign rd_mux =
      (bus.addr == `HDTG_ADDR_CTRL)    ? {27'h0, ctrl_reg} :
      (bus.addr == `HDTG_ADDR_AMP)     ? {24'h0, amp_reg} :
      (bus.addr == `HDTG_ADDR_SQUELCH) ? {25'h0, squelch_reg} :
      (bus.addr == `HDTG_ADDR_GAIN)    ? {25'h0, bw_reg, gain_reg} :
      (bus.addr == `HDTG_ADDR_STATUS)  ? {16'h0, level_reg, 3'h0, squelched,
                                          halt_reg, alarm_reg, warn_reg, short_reg} :
      (bus.addr == `HDTG_ADDR_TEMP)    ? {22'h0, temp_last_reg} : 32'h0;

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         ctrl_reg    <= `HDTG_CTRL_RST;
         amp_reg     <= `HDTG_AMP_RST;
         squelch_reg <= `HDTG_SQUELCH_RST;
         gain_reg    <= `HDTG_GAIN_RST;
         bw_reg      <= `HDTG_BW_RST;
         rdata_reg   <= 32'h0;
      end else begin
         if (wr_ctrl) ctrl_reg <= bus.wdata[`HDTG_CTRL_W-1:0];
         if (wr_amp) amp_reg <= bus.wdata[7:0];
         if (wr_sq) squelch_reg <= bus.wdata[6:0];
         if (wr_gain) begin
            gain_reg <= bus.wdata[`HDTG_GAIN_W-1:0];
            bw_reg   <= bus.wdata[`HDTG_BW_LSB+2:`HDTG_BW_LSB];
         end
         rdata_reg <= bus.rd ? rd_mux : 32'h0;
      end
   end

   // ==========================================
   // pwm duty decoder
   // counters saturate so a stuck pin cannot wrap into a false duty
   wire pwm_rise = pwm_s && !pwm_last_reg;
   wire [CNT_W-1:0] cnt_max = {CNT_W{1'b1}};

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         pwm_last_reg  <= 1'b0;
         pwm_seen_reg  <= 1'b0;
         pwm_tick_reg  <= 1'b0;
         per_cnt_reg   <= '0;
         high_cnt_reg  <= '0;
         meas_per_reg  <= '0;
         meas_high_reg <= '0;
      end else begin
         pwm_last_reg <= pwm_s;
         pwm_tick_reg <= pwm_rise && pwm_seen_reg;
         if (pwm_rise) begin
            pwm_seen_reg  <= 1'b1;
            meas_per_reg  <= per_cnt_reg;
            meas_high_reg <= high_cnt_reg;
            per_cnt_reg   <= CNT_W'(1);
            high_cnt_reg  <= CNT_W'(1);
         end else begin
            if (per_cnt_reg != cnt_max) per_cnt_reg <= per_cnt_reg + CNT_W'(1);
            if (pwm_s && high_cnt_reg != cnt_max) high_cnt_reg <= high_cnt_reg + CNT_W'(1);
         end
      end
   end

   // code = (2*high - period) * 127 / period, clipped to +-127
   wire signed [31:0] hi_x2   = {{(31-CNT_W){1'b0}}, meas_high_reg, 1'b0};
   wire signed [31:0] per_ext = {{(32-CNT_W){1'b0}}, meas_per_reg};
   wire signed [31:0] duty_num = (hi_x2 - per_ext) * 32'sd127;
   wire signed [31:0] duty_q  = (per_ext == 32'sd0) ? 32'sd0 : duty_num / per_ext;
   wire [7:0] pin_code =
      (duty_q > 32'sd127)  ? 8'h7F :
      (duty_q < -32'sd127) ? 8'h81 : duty_q[7:0];

   // ==========================================
   // slow oscillator tick
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         slow_div_reg  <= 16'h0;
         slow_tick_reg <= 1'b0;
      end else begin
         slow_tick_reg <= slow_div_reg == 16'(SLOW_DIV - 1);
         slow_div_reg  <= (slow_div_reg == 16'(SLOW_DIV - 1)) ? 16'h0 : slow_div_reg + 16'h1;
      end
   end

   // ==========================================
   // level source, squelch and slew filter
   // register ERM follows the slow clock; every other case the input period
   wire level_tick = (ctrl_reg.source_select && load_erm) ? slow_tick_reg
                                                           : pwm_tick_reg;
   wire [7:0] level_new = ctrl_reg.source_select ? amp_reg : pin_code;
   wire [7:0] level_abs = level_reg[7] ? 8'(-level_reg) : level_reg;
   wire in_window = level_abs <= {1'b0, squelch_reg};
   assign squelched = sq_cnt_reg > `HDTG_SQUELCH_PERIODS;

   wire signed [8:0] slew_diff = $signed({level_reg[7], level_reg}) - $signed({filt_reg[7], filt_reg});
   wire signed [8:0] slew_step = $signed({5'h0, 1'b0, bw_reg}) + 9'sd1;
   wire [7:0] filt_next =
      (slew_diff > slew_step)  ? 8'(filt_reg + slew_step[7:0]) :
      (slew_diff < -slew_step) ? 8'(filt_reg - slew_step[7:0]) : level_reg;

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         level_reg  <= 8'h00;
         filt_reg   <= 8'h00;
         sq_cnt_reg <= 10'h000;
      end else begin
         if (level_tick) level_reg <= level_new;
         if (slow_tick_reg) filt_reg <= filt_next;
         if (!in_window) sq_cnt_reg <= 10'h000;
         else if (level_tick && !squelched) sq_cnt_reg <= sq_cnt_reg + 10'h001;
      end
   end

   // ==========================================
   // drive output
   // lra carrier polarity follows the input pin, so its frequency sets the carrier
   wire drive_off = !hap_active || short_s || halt_reg;
   wire [7:0] dac_next =
      (drive_off || squelched) ? 8'h00 :
      (load_lra && !pwm_s)     ? 8'(-filt_reg) : filt_reg;

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         dac_reg    <= 8'h00;
         ground_reg <= 1'b1;
         short_reg  <= 1'b0;
      end else begin
         dac_reg    <= dac_next;
         ground_reg <= drive_off;
         short_reg  <= short_s;
      end
   end

   // ==========================================
   // temperature monitor
   wire chip_active = !host_driven_mode || proximity_scan_interval != 3'h0
                      || ctrl_reg.load_select != `HDTG_LOAD_OFF;
   wire may_run   = ctrl_reg.always_measure || chip_active;
   wire temp_due  = slow_tick_reg && tdiv_reg == `HDTG_TEMP_PERIOD - 11'h1;
   wire meas_done = ts_reg == hdtg_pkg::TS_MEAS && temp_valid;
   wire warn_next  = temp_code > WARN_CODE;
   wire alarm_next = temp_code > ALARM_CODE;

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         tdiv_reg <= 11'h000;
         ts_reg   <= hdtg_pkg::TS_IDLE;
      end else begin
         if (slow_tick_reg) tdiv_reg <= temp_due ? 11'h000 : tdiv_reg + 11'h001;
         unique case (ts_reg)
            hdtg_pkg::TS_IDLE: begin
               if (temp_due && may_run) ts_reg <= hdtg_pkg::TS_WAIT;
            end
            hdtg_pkg::TS_WAIT: begin
               // a conversion only postpones the sample in default mode
               if (!may_run) ts_reg <= hdtg_pkg::TS_IDLE;
               else if (ctrl_reg.always_measure || !adc_busy) ts_reg <= hdtg_pkg::TS_MEAS;
            end
            hdtg_pkg::TS_MEAS: begin
               if (temp_valid) ts_reg <= hdtg_pkg::TS_IDLE;
            end
         endcase
      end
   end

   wire start_next = ts_reg == hdtg_pkg::TS_WAIT && may_run
                     && (ctrl_reg.always_measure || !adc_busy);

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         start_reg      <= 1'b0;
         temp_last_reg  <= 10'h000;
         warn_reg       <= 1'b0;
         alarm_reg      <= 1'b0;
         halt_reg       <= 1'b0;
         warn_edge_reg  <= 1'b0;
         alarm_edge_reg <= 1'b0;
         discard_reg    <= 1'b0;
         restart_reg    <= 1'b0;
      end else begin
         start_reg      <= start_next;
         warn_edge_reg  <= meas_done && warn_next != warn_reg;
         alarm_edge_reg <= meas_done && alarm_next != alarm_reg;
         discard_reg    <= meas_done && alarm_next && !alarm_reg;
         restart_reg    <= meas_done && !alarm_next && alarm_reg;
         if (meas_done) begin
            temp_last_reg <= temp_code;
            warn_reg      <= warn_next;
            alarm_reg     <= alarm_next;
            halt_reg      <= alarm_next;
         end
      end
   end

   // ==========================================
   // outputs
   assign bus_rdata          = rdata_reg;
   assign dac_code           = dac_reg;
   assign motor_ground       = ground_reg;
   assign haptic_output_gain = gain_reg;
   assign motor_short_flag   = short_reg;
   assign thermal_warn_flag  = warn_reg;
   assign thermal_alarm_flag = alarm_reg;
   assign warn_edge          = warn_edge_reg;
   assign alarm_edge         = alarm_edge_reg;
   assign temp_start         = start_reg;
   assign ops_halt           = halt_reg;
   assign results_discard    = discard_reg;
   assign cycle_restart      = restart_reg;

   // ==========================================
   // checks
   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);

   idle_off_a: assert property (
      ctrl_reg.load_select == `HDTG_LOAD_OFF |=> dac_reg == 8'h00 && ground_reg)
      else $error("drive active with load select zero");
   short_gnd_a: assert property (
      short_reg |-> ground_reg && $past(dac_next) == 8'h00)
      else $error("short flag without grounded outputs");
   alarm_halt_a: assert property (
      $rose(alarm_reg) |-> halt_reg ##1 (dac_reg == 8'h00 && ground_reg))
      else $error("alarm did not halt drive");
   discard_a: assert property (
      $rose(halt_reg) |-> discard_reg && !restart_reg)
      else $error("shutdown without result discard");
   squelch_a: assert property (
      sq_cnt_reg > 10'h200 |=> dac_reg == 8'h00)
      else $error("output not squelched");
   squelch_rst_a: assert property (
      !in_window |=> sq_cnt_reg == 10'h000)
      else $error("squelch count not restarted");
   sat_range_a: assert property (
      pin_code != 8'h80 && dac_reg != 8'h80)
      else $error("level code outside +-127");
   temp_hold_a: assert property (
      start_reg |-> $past(ctrl_reg.always_measure) || !$past(adc_busy))
      else $error("temperature sample during conversion");
   warn_edge_a: assert property (
      $changed(warn_reg) |-> warn_edge_reg)
      else $error("warning edge not flagged");
   resume_a: assert property (
      $fell(halt_reg) && hap_active && !short_s && !squelched |=> !ground_reg)
      else $error("haptics did not resume after shutdown");
endmodule : hdtg_top
`default_nettype wire

// ===== verif/hdtg_motor_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// pwm source and motor load stand-in
module hdtg_motor_model (
   input  wire logic        mclk,
   input  wire logic        run,
   input  wire logic [15:0] high_cyc,
   input  wire logic [15:0] per_cyc,
   input  wire logic        short_req,
   output logic             pwm_in,
   output logic             short_detect
);
   logic [15:0] cnt;

   initial begin
      cnt          = 16'h0000;
      pwm_in       = 1'b0;
      short_detect = 1'b0;
   end

   // grounded pin when stopped, so register erm never sees a stray carrier
   always @(posedge mclk) begin
      if (!run) begin
         cnt    <= 16'h0000;
         pwm_in <= 1'b0;
      end else begin
         cnt    <= (cnt + 16'h0001 >= per_cyc) ? 16'h0000 : cnt + 16'h0001;
         pwm_in <= (cnt < high_cyc);
      end
   end

   // over-current comparator follows the requested fault
   always @(posedge mclk) begin
      short_detect <= short_req;
   end
endmodule : hdtg_motor_model
`default_nettype wire

// ===== verif/hdtg_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "hdtg_defines.svh"
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin failures++; \
   $display("ERROR %s exp %0h got %0h", n, e, g); end end

module hdtg_top_tb;
   // ==========================================
   // settings and wiring
   localparam int         SDIV    = 8;
   localparam int         LIMIT   = 80000;
   localparam logic [9:0] WARN_C  = 10'h1E0;
   localparam logic [9:0] ALARM_C = 10'h26C;
   hdtg_pkg::hdtg_bus_t bus;
   logic        mclk, rstn, pwm_in, short_detect, host_driven_mode, adc_busy;
   logic        temp_valid, run, short_req, motor_ground, motor_short_flag;
   logic        thermal_warn_flag, thermal_alarm_flag, warn_edge, alarm_edge;
   logic        temp_start, ops_halt, results_discard, cycle_restart;
   logic [2:0]  proximity_scan_interval;
   logic [9:0]  temp_code, reply_code;
   logic [15:0] high_c, per_c;
   logic [31:0] bus_rdata;
   logic [7:0]  dac_code;
   logic [3:0]  haptic_output_gain;
   int          failures, samples_checked, cyc_count, n_we, n_ae, n_dis, n_rs;
   bit          seen;

   hdtg_top #(.SLOW_DIV(SDIV), .WARN_CODE(WARN_C), .ALARM_CODE(ALARM_C)) u_hdtg_top (
      .mclk(mclk), .rstn(rstn), .bus_addr(bus.addr), .bus_wdata(bus.wdata),
      .bus_wr(bus.wr), .bus_rd(bus.rd), .bus_rdata(bus_rdata), .pwm_in(pwm_in),
      .short_detect(short_detect), .host_driven_mode(host_driven_mode),
      .proximity_scan_interval(proximity_scan_interval), .adc_busy(adc_busy),
      .temp_valid(temp_valid), .temp_code(temp_code), .dac_code(dac_code),
      .motor_ground(motor_ground), .haptic_output_gain(haptic_output_gain),
      .motor_short_flag(motor_short_flag), .thermal_warn_flag(thermal_warn_flag),
      .thermal_alarm_flag(thermal_alarm_flag), .warn_edge(warn_edge),
      .alarm_edge(alarm_edge), .temp_start(temp_start), .ops_halt(ops_halt),
      .results_discard(results_discard), .cycle_restart(cycle_restart));

   hdtg_motor_model u_hdtg_motor_model (
      .mclk(mclk), .run(run), .high_cyc(high_c), .per_cyc(per_c),
      .short_req(short_req), .pwm_in(pwm_in), .short_detect(short_detect));

   always #5 mclk = ~mclk;

   // sensor answers every request, so no measurement is ever left hanging
   always @(posedge mclk) begin
      temp_valid <= (temp_start === 1'b1);
      temp_code  <= reply_code;
      if (warn_edge === 1'b1) n_we++;
      if (alarm_edge === 1'b1) n_ae++;
      if (results_discard === 1'b1) n_dis++;
      if (cycle_restart === 1'b1) n_rs++;
      cyc_count++;
      if (cyc_count == LIMIT) begin
         failures++;
         close_out();
      end
   end

   // ==========================================
   // bus and helpers
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      bus.addr  <= a;
      bus.wdata <= d;
      bus.wr    <= 1'b1;
      @(posedge mclk);
      bus.wr    <= 1'b0;
   endtask : wr_reg

   task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] e);
      @(posedge mclk);
      bus.addr <= a;
      bus.rd   <= 1'b1;
      @(posedge mclk);
      bus.rd   <= 1'b0;
      #1;
      `CHK(n, e, bus_rdata)
   endtask : rd_chk

   task automatic cycles(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : cycles

   task automatic wait_start(input int n);
      seen = 1'b0;
      repeat (n) begin
         @(posedge mclk);
         #1;
         if (temp_start === 1'b1) begin
            seen = 1'b1;
            break;
         end
      end
   endtask : wait_start

   function automatic logic [7:0] exp_code(input int h, input int p);
      int v;
      v = ((2 * h - p) * 127) / p;
      if (v > 127) v = 127;
      if (v < -127) v = -127;
      return v[7:0];
   endfunction : exp_code

   // ==========================================
   // scenarios
   task automatic t_erm_reg;
      `CHK("rst gnd", 1'b1, motor_ground)
      rd_chk("unmapped", 8'h20, 32'h0000_0000);
      wr_reg(`HDTG_ADDR_GAIN, 32'h0000_0073);
      wr_reg(`HDTG_ADDR_AMP, 32'h0000_0040);
      wr_reg(`HDTG_ADDR_CTRL, 32'h0000_000E);
      cycles(200);
      `CHK("erm dac", 8'h40, dac_code)
      `CHK("erm gnd", 1'b0, motor_ground)
      `CHK("gain", 4'h3, haptic_output_gain)
      rd_chk("ctrl reg", `HDTG_ADDR_CTRL, 32'h0000_000E);
      wr_reg(`HDTG_ADDR_AMP, 32'h0000_00C0);
      cycles(3);
      `CHK("slew", 1'b0, dac_code[7])
      cycles(300);
      `CHK("erm neg", 8'hC0, dac_code)
   endtask : t_erm_reg

   task automatic t_squelch;
      wr_reg(`HDTG_ADDR_SQUELCH, 32'h0000_0010);
      wr_reg(`HDTG_ADDR_AMP, 32'h0000_0005);
      cycles(200);
      `CHK("in window", 8'h05, dac_code)
      cycles(4300);
      `CHK("squelched", 8'h00, dac_code)
      rd_chk("status", `HDTG_ADDR_STATUS, 32'h0000_0510);
      wr_reg(`HDTG_ADDR_AMP, 32'h0000_0020);
      cycles(100);
      `CHK("unsquelch", 8'h20, dac_code)
      wr_reg(`HDTG_ADDR_SQUELCH, 32'h0000_0000);
   endtask : t_squelch

   task automatic t_pin;
      int hs[4] = '{75, 25, 50, 99};
      per_c <= 16'd100;
      run   <= 1'b1;
      wr_reg(`HDTG_ADDR_CTRL, 32'h0000_0002);
      foreach (hs[i]) begin
         high_c <= 16'(hs[i]);
         cycles(700);
         `CHK("pin erm", exp_code(hs[i], 100), dac_code)
      end
      high_c <= 16'd75;
      wr_reg(`HDTG_ADDR_CTRL, 32'h0000_0001);
      cycles(700);
      @(posedge pwm_in);
      cycles(20);
      `CHK("lra high", exp_code(75, 100), dac_code)
      @(negedge pwm_in);
      cycles(20);
      `CHK("lra low", exp_code(25, 100), dac_code)
      wr_reg(`HDTG_ADDR_AMP, 32'h0000_0030);
      wr_reg(`HDTG_ADDR_CTRL, 32'h0000_0005);
      cycles(700);
      @(posedge pwm_in);
      cycles(20);
      `CHK("lra reg", 8'h30, dac_code)
      // fast carrier keeps the 513-period squelch wait short
      per_c  <= 16'd8;
      high_c <= 16'd4;
      wr_reg(`HDTG_ADDR_SQUELCH, 32'h0000_0010);
      wr_reg(`HDTG_ADDR_AMP, 32'h0000_0005);
      cycles(4300);
      `CHK("lra squelch", 8'h00, dac_code)
      rd_chk("lra status", `HDTG_ADDR_STATUS, 32'h0000_0510);
      wr_reg(`HDTG_ADDR_SQUELCH, 32'h0000_0000);
      wr_reg(`HDTG_ADDR_AMP, 32'h0000_0030);
   endtask : t_pin

   task automatic t_short;
      run <= 1'b0;
      wr_reg(`HDTG_ADDR_CTRL, 32'h0000_000E);
      cycles(200);
      short_req <= 1'b1;
      cycles(6);
      `CHK("short flag", 1'b1, motor_short_flag)
      `CHK("short gnd", 1'b1, motor_ground)
      `CHK("short dac", 8'h00, dac_code)
      short_req <= 1'b0;
      cycles(200);
      `CHK("resume gnd", 1'b0, motor_ground)
      `CHK("resume dac", 8'h30, dac_code)
      wr_reg(`HDTG_ADDR_CTRL, 32'h0000_0003);
      cycles(5);
      `CHK("load 11", 1'b1, motor_ground)
   endtask : t_short

   task automatic t_temp;
      wr_reg(`HDTG_ADDR_CTRL, 32'h0000_0000);
      wait_start(8300);
      `CHK("idle no meas", 1'b0, seen)
      proximity_scan_interval <= 3'h1;
      adc_busy <= 1'b1;
      wait_start(8300);
      `CHK("busy defer", 1'b0, seen)
      adc_busy <= 1'b0;
      wait_start(20);
      `CHK("after conv", 1'b1, seen)
      proximity_scan_interval <= 3'h0;
      host_driven_mode        <= 1'b0;
      wait_start(8300);
      `CHK("touch meas", 1'b1, seen)
      host_driven_mode <= 1'b1;
      adc_busy   <= 1'b1;
      reply_code <= ALARM_C + 10'h001;
      wr_reg(`HDTG_ADDR_CTRL, 32'h0000_001E);
      wait_start(8300);
      `CHK("always meas", 1'b1, seen)
      cycles(4);
      `CHK("alarm", 1'b1, thermal_alarm_flag)
      `CHK("warn", 1'b1, thermal_warn_flag)
      `CHK("halt", 1'b1, ops_halt)
      `CHK("halt gnd", 1'b1, motor_ground)
      `CHK("edges", 2, n_ae + n_we)
      `CHK("discard", 1, n_dis)
      reply_code <= ALARM_C;
      wait_start(8300);
      cycles(4);
      `CHK("alarm off", 1'b0, thermal_alarm_flag)
      `CHK("halt off", 1'b0, ops_halt)
      `CHK("restart", 1, n_rs)
      `CHK("alarm edge", 2, n_ae)
      `CHK("drive gnd", 1'b0, motor_ground)
      reply_code <= WARN_C;
      wait_start(8300);
      cycles(4);
      `CHK("warn off", 1'b0, thermal_warn_flag)
      `CHK("warn edge", 2, n_we)
      `CHK("drive back", 8'h30, dac_code)
      rd_chk("temp reg", `HDTG_ADDR_TEMP, {22'h0, WARN_C});
   endtask : t_temp

   task automatic close_out;
      $display("checks %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : close_out

   // ==========================================
   // main sequence
   initial begin
      mclk                    = 1'b0;
      rstn                    = 1'b0;
      bus                     = '0;
      run                     = 1'b0;
      short_req               = 1'b0;
      high_c                  = 16'h0000;
      per_c                   = 16'h0064;
      host_driven_mode        = 1'b1;
      proximity_scan_interval = 3'h0;
      adc_busy                = 1'b0;
      reply_code              = 10'h100;
      temp_valid              = 1'b0;
      temp_code               = 10'h000;
      repeat (16) @(posedge mclk);
      rstn <= 1'b1;
      cycles(2);
      t_erm_reg();
      t_squelch();
      t_pin();
      t_short();
      t_temp();
      close_out();
   end
endmodule : hdtg_top_tb
`default_nettype wire
